// >>> include/ddrs_pkg.sv
// Shared constants and carrier types for the burst-of-two DDR SRAM core.
// Assumes one link clock pair (rise and fall) and a faster system clock.
package ddrs_pkg;

    // Data path geometry
    localparam int DW = 18;
    localparam int AW = 22;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int DEPTH = 4194304;

    // Synchroniser depths
    localparam int PIN_STAGES = 3;
    localparam int CDC_STAGES = 2;

    // Link cycles to wait before the clock strap is caught
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    // Counts in system clock cycles
    localparam int DLL_LOCK_CYCLES = 1024;
    localparam int IMP_CAL_CYCLES = 1024;
    localparam logic [10:0] LOCK_MAX = 11'(DLL_LOCK_CYCLES - 1);
    localparam logic [9:0] IMP_MAX = 10'(IMP_CAL_CYCLES - 1);

    // Mask and reset values
    localparam logic [LANES-1:0] MASK_KEEP = 2'h3;
    localparam logic [LANES-1:0] MASK_ALL = 2'h0;
    localparam logic [DW-1:0] DATA_RST = 18'h00000;
    localparam logic [AW-1:0] ADDR_RST = 22'h000000;

    // Burst position of the second word
    localparam logic ADDR_LSB_FLIP = 1'h1;

    // One staged write: address, both words and their lane masks
    typedef struct packed {
        logic vld;
        logic [AW-1:0] addr;
        logic [DW-1:0] w0;
        logic [DW-1:0] w1;
        logic [LANES-1:0] m0_n;
        logic [LANES-1:0] m1_n;
    } ddrs_wr_t;

    // One loaded read and the latency mode it was loaded under
    typedef struct packed {
        logic vld;
        logic late;
        logic [AW-1:0] addr;
    } ddrs_rd_t;

endpackage

// >>> core/ddrs_sync.sv
// Level synchroniser with optional agreement filter on the last two stages.
// Assumes d changes slowly against clk; rst is asynchronous, active high.
`timescale 1ns/1ns
module ddrs_sync #(
    parameter int STAGES = 2,
    parameter bit FILTER = 1'b0,
    parameter bit RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);

    logic [STAGES-1:0] st_reg;
    logic filt_reg;

    // Shift chain; the next stage reads the first flop, and with two stages the agreement filter reads it too
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= {STAGES{RST_VAL}};
        end else begin
            st_reg <= {st_reg[STAGES-2:0], d};
        end
    end

    // Change taken only once the last two stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_reg <= RST_VAL;
        end else if (st_reg[STAGES-1] == st_reg[STAGES-2]) begin
            filt_reg <= st_reg[STAGES-1];
        end
    end

    assign q = FILTER ? filt_reg : st_reg[STAGES-1];

endmodule

// >>> core/ddrs_core.sv
// Burst-of-two double-data-rate pipelined SRAM core with posted writes.
// Assumes the controller drives k_clk; its fall stands for the negative
// input clock. Output registers launch on the same pair (zero C skew).
`timescale 1ns/1ns
module ddrs_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic k_clk,
    input wire logic load_n,
    input wire logic rd_wr,
    input wire logic [ddrs_pkg::AW-1:0] addr,
    input wire logic [ddrs_pkg::LANES-1:0] byte_lane_mask_n,
    input wire logic [ddrs_pkg::DW-1:0] dq_in,
    output logic [ddrs_pkg::DW-1:0] dq_out,
    output logic dq_oe,
    input wire logic dll_disable_n,
    input wire logic c_clk_p,
    input wire logic c_clk_n,
    output logic single_clock_mode,
    output logic dll_locked,
    output logic imp_update,
    output logic link_busy
);
    import ddrs_pkg::*;

    logic link_rst;
    logic dll_on_link;
    logic dll_on_m;
    logic c_high;
    logic busy_m;
    logic cmd_rd;
    logic cmd_wr;
    logic commit;
    logic [AW-1:0] ra_addr2;
    logic [AW-1:0] hold_addr2;
    logic [DW-1:0] f0;
    logic [DW-1:0] f1;
    logic [DW-1:0] mem [0:DEPTH-1];
    ddrs_rd_t ra_reg;
    ddrs_wr_t wb_reg;
    ddrs_wr_t wb_full;
    ddrs_wr_t hold_reg;
    ddrs_wr_t hold_next;
    logic wa_vld_reg;
    logic [AW-1:0] wa_addr_reg;
    logic [DW-1:0] wneg_w1_reg;
    logic [LANES-1:0] wneg_m1_reg;
    logic [DW-1:0] rw0_reg;
    logic [DW-1:0] rw1_reg;
    logic lpend_reg;
    logic eneg_reg;
    logic [DW-1:0] q_pos_reg;
    logic [DW-1:0] q_neg_reg;
    logic pos_oe_reg;
    logic neg_oe_reg;
    logic single_reg;
    logic strap_done_reg;
    logic [2:0] strap_cnt_reg;
    logic busy_reg;
    logic [10:0] lock_cnt_reg;
    logic [9:0] imp_cnt_reg;
    logic imp_pulse_reg;

    // Lane-wise merge; a high mask bit keeps the old lane
    function automatic logic [DW-1:0] lane_merge(
        input logic [DW-1:0] old_w,
        input logic [DW-1:0] new_w,
        input logic [LANES-1:0] m_n
    );
        logic [DW-1:0] v;
        v = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!m_n[i]) begin
                v[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return v;
    endfunction

    // Overlay one staged write onto a word read for address a
    function automatic logic [DW-1:0] overlay(
        input logic [DW-1:0] base,
        input logic [AW-1:0] a,
        input ddrs_wr_t w
    );
        logic [DW-1:0] v;
        v = base;
        if (w.vld && w.addr == a) begin
            v = lane_merge(base, w.w0, w.m0_n);
        end else if (w.vld && {w.addr[AW-1:1], ~w.addr[0]} == a) begin
            v = lane_merge(base, w.w1, w.m1_n);
        end
        return v;
    endfunction

    // Link reset: asserts at once, releases on the link clock
    ddrs_sync #(
        .STAGES(CDC_STAGES),
        .FILTER(1'b0),
        .RST_VAL(1'b1)
    ) u_link_rst (
        .clk(k_clk),
        .rst(rst),
        .d(1'b0),
        .q(link_rst)
    );

    // Latency select pin, filtered into the link domain
    ddrs_sync #(
        .STAGES(PIN_STAGES),
        .FILTER(1'b1),
        .RST_VAL(1'b0)
    ) u_dll_link (
        .clk(k_clk),
        .rst(link_rst),
        .d(dll_disable_n),
        .q(dll_on_link)
    );

    // Same pin for the lock counter on the system clock
    ddrs_sync #(
        .STAGES(PIN_STAGES),
        .FILTER(1'b1),
        .RST_VAL(1'b0)
    ) u_dll_m (
        .clk(mclk),
        .rst(rst),
        .d(dll_disable_n),
        .q(dll_on_m)
    );

    // Output clock strap pins, both must read high
    ddrs_sync #(
        .STAGES(PIN_STAGES),
        .FILTER(1'b1),
        .RST_VAL(1'b0)
    ) u_strap (
        .clk(k_clk),
        .rst(link_rst),
        .d(c_clk_p & c_clk_n),
        .q(c_high)
    );

    // Activity level handed to the system clock
    ddrs_sync #(
        .STAGES(CDC_STAGES),
        .FILTER(1'b0),
        .RST_VAL(1'b0)
    ) u_busy (
        .clk(mclk),
        .rst(rst),
        .d(busy_reg),
        .q(busy_m)
    );

    assign cmd_rd = !load_n && rd_wr;
    assign cmd_wr = !load_n && !rd_wr;

    assign ra_addr2 = {ra_reg.addr[AW-1:1], ra_reg.addr[0] ^ ADDR_LSB_FLIP};
    assign hold_addr2 = {hold_reg.addr[AW-1:1],
                         hold_reg.addr[0] ^ ADDR_LSB_FLIP};

    // second word joins the staged write after the fall
    assign wb_full = '{vld: wb_reg.vld, addr: wb_reg.addr, w0: wb_reg.w0,
                       w1: wneg_w1_reg, m0_n: wb_reg.m0_n,
                       m1_n: wneg_m1_reg};

    // newest data wins: staged write over held write over array
    assign f0 = overlay(overlay(mem[ra_reg.addr], ra_reg.addr, hold_reg),
                        ra_reg.addr, wb_full);
    assign f1 = overlay(overlay(mem[ra_addr2], ra_addr2, hold_reg),
                        ra_addr2, wb_full);

    // held write leaves only when a newer write arrives or no read is loaded
    assign commit = hold_reg.vld && (wb_reg.vld || !cmd_rd);
    assign hold_next = wb_reg.vld ? wb_full : (commit ? '0 : hold_reg);

    // read address register; loaded on every rise
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            ra_reg <= '0;
        end else begin
            ra_reg <= '{vld: cmd_rd, late: dll_on_link, addr: addr};
        end
    end

    // write address register; pipelined on every rise
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            wa_vld_reg <= 1'b0;
            wa_addr_reg <= ADDR_RST;
        end else begin
            wa_vld_reg <= cmd_wr;
            wa_addr_reg <= addr;
        end
    end

    // first write word and its lane mask on the rise
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            wb_reg <= '0;
        end else begin
            wb_reg <= '{vld: wa_vld_reg, addr: wa_addr_reg, w0: dq_in,
                        w1: DATA_RST, m0_n: byte_lane_mask_n,
                        m1_n: MASK_KEEP};
        end
    end

    // second write word and mask on the fall
    always_ff @(negedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            wneg_w1_reg <= DATA_RST;
            wneg_m1_reg <= MASK_KEEP;
        end else begin
            wneg_w1_reg <= dq_in;
            wneg_m1_reg <= byte_lane_mask_n;
        end
    end

    // holding register takes each staged write and clears once it commits
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // both words of a posted write enter the array together
    always_ff @(posedge k_clk) begin
        if (commit) begin
            mem[hold_reg.addr] <= lane_merge(mem[hold_reg.addr],
                                             hold_reg.w0, hold_reg.m0_n);
            mem[hold_addr2] <= lane_merge(mem[hold_addr2],
                                          hold_reg.w1, hold_reg.m1_n);
        end
    end

    // both burst words fetched one rise after the load
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            rw0_reg <= DATA_RST;
            rw1_reg <= DATA_RST;
            lpend_reg <= 1'b0;
            eneg_reg <= 1'b0;
        end else begin
            if (ra_reg.vld) begin
                rw0_reg <= f0;
                rw1_reg <= f1;
            end
            lpend_reg <= ra_reg.vld && ra_reg.late;
            eneg_reg <= ra_reg.vld && !ra_reg.late;
        end
    end

    // first word of a fast read on the next rise; second word of a slow read one rise later
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            q_pos_reg <= DATA_RST;
            pos_oe_reg <= 1'b0;
        end else if (ra_reg.vld && !ra_reg.late) begin
            q_pos_reg <= f0;
            pos_oe_reg <= 1'b1;
        end else if (lpend_reg) begin
            q_pos_reg <= rw1_reg;
            pos_oe_reg <= 1'b1;
        end else begin
            pos_oe_reg <= 1'b0;
        end
    end

    // word on the fall: second of a fast read, first of a slow one
    always_ff @(negedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            q_neg_reg <= DATA_RST;
            neg_oe_reg <= 1'b0;
        end else if (eneg_reg) begin
            q_neg_reg <= rw1_reg;
            neg_oe_reg <= 1'b1;
        end else if (lpend_reg) begin
            q_neg_reg <= rw0_reg;
            neg_oe_reg <= 1'b1;
        end else begin
            neg_oe_reg <= 1'b0;
        end
    end

    // outputs float once no word is launched; floating from reset
    // The clock level picks the register that launched last.
    assign dq_out = k_clk ? q_pos_reg : q_neg_reg;
    assign dq_oe = k_clk ? pos_oe_reg : neg_oe_reg;

    // strap caught once, after the pin filter has settled
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            single_reg <= 1'b0;
            strap_done_reg <= 1'b0;
            strap_cnt_reg <= 3'h0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 3'h1;
            if (strap_cnt_reg == STRAP_SETTLE) begin
                single_reg <= c_high;
                strap_done_reg <= 1'b1;
            end
        end
    end

    assign single_clock_mode = single_reg;

    // Anything still in flight keeps the busy level up
    always_ff @(posedge k_clk or posedge link_rst) begin
        if (link_rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= ra_reg.vld || lpend_reg || eneg_reg || wa_vld_reg
                        || wb_reg.vld || hold_reg.vld;
        end
    end

    assign link_busy = busy_m;

    // lock counter; restarts whenever the DLL is switched off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_cnt_reg <= 11'h000;
        end else if (!dll_on_m) begin
            lock_cnt_reg <= 11'h000;
        end else if (lock_cnt_reg != LOCK_MAX) begin
            lock_cnt_reg <= lock_cnt_reg + 11'h001;
        end
    end

    assign dll_locked = dll_on_m && (lock_cnt_reg == LOCK_MAX);

    // free-running update period from power up
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            imp_cnt_reg <= 10'h000;
            imp_pulse_reg <= 1'b0;
        end else begin
            imp_cnt_reg <= imp_cnt_reg + 10'h001;
            imp_pulse_reg <= (imp_cnt_reg == IMP_MAX);
        end
    end

    assign imp_update = imp_pulse_reg;

    default clocking cb @(posedge k_clk); endclocking
    default disable iff (link_rst);

    sequence s_wr_flow;
        wa_vld_reg ##1 wb_reg.vld ##1 hold_reg.vld;
    endsequence

    sequence s_quiet;
        !cmd_rd [*3];
    endsequence

    a_rd_addr_kept: assert property (
        cmd_rd |=> ra_reg.vld && ra_reg.addr == $past(addr))
        else $error("read address not stored");
    a_wr_pipe_flow: assert property (
        cmd_wr |=> s_wr_flow)
        else $error("write did not reach holding register");
    a_fast_latency: assert property (
        ra_reg.vld && !ra_reg.late |=> pos_oe_reg && q_pos_reg == $past(f0))
        else $error("one cycle read word wrong");
    a_slow_latency: assert property (
        ra_reg.vld && ra_reg.late |=> ##1 pos_oe_reg
        && q_pos_reg == $past(f1, 2))
        else $error("late read second word wrong");
    a_back_reads: assert property (
        cmd_rd ##1 cmd_rd |=> ra_reg.vld && $past(ra_reg.vld))
        else $error("back to back read dropped");
    a_quiet_float: assert property (
        s_quiet |=> !pos_oe_reg && !neg_oe_reg)
        else $error("outputs still driven after reads ended");
    a_posted_keep: assert property (
        hold_reg.vld && cmd_rd && !wb_reg.vld |=> hold_reg == $past(hold_reg))
        else $error("held write lost during read");
    a_bypass_new: assert property (
        ra_reg.vld && wb_reg.vld && ra_reg.addr == wb_reg.addr
        && wb_reg.m0_n == MASK_ALL |-> f0 == wb_reg.w0)
        else $error("read missed newest write data");
    a_strap_fixed: assert property (
        strap_done_reg && $past(strap_done_reg) |-> $stable(single_reg))
        else $error("clock mode changed in operation");
    a_imp_period: assert property (
        @(posedge mclk) disable iff (rst)
        imp_update |=> !imp_update [*8])
        else $error("impedance update too frequent");
    a_lock_count: assert property (
        @(posedge mclk) disable iff (rst)
        dll_on_m && !dll_locked && $past(dll_on_m)
        |=> lock_cnt_reg == $past(lock_cnt_reg) + 11'h001 || !dll_on_m)
        else $error("lock counter stalled");

endmodule

// >>> tb/ddrs_ctrl_model.sv
// Memory controller model: runs the link clock and drives one command
// per link cycle. Assumes the bench calls step back to back.
`timescale 1ns/1ns
module ddrs_ctrl_model (
    output logic k_clk,
    output logic load_n,
    output logic rd_wr,
    output logic [ddrs_pkg::AW-1:0] addr,
    output logic [ddrs_pkg::LANES-1:0] byte_lane_mask_n,
    output logic [ddrs_pkg::DW-1:0] dq_in,
    input wire logic [ddrs_pkg::DW-1:0] dq_out,
    input wire logic dq_oe
);
    import ddrs_pkg::*;
    int hc = 0;
    logic [DW-1:0] sq [0:1023];
    logic so [0:1023];
    ddrs_wr_t p_wr = '0;
    ddrs_wr_t pp_wr = '0;

    // Free running link clock; 62 + 63 ns holds 125 ns on a 1 ns grid
    initial begin
        k_clk = 1'b0;
        load_n = 1'b1;
        rd_wr = 1'b0;
        addr = ADDR_RST;
        byte_lane_mask_n = MASK_KEEP;
        dq_in = DATA_RST;
        forever begin
            #62 k_clk = 1'b1;
            #63 k_clk = 1'b0;
        end
    end

    // Edge count; a sample stored at hc is the phase after edge hc
    always @(posedge k_clk or negedge k_clk) begin
        hc <= hc + 1;
    end

    // Sample 20 ns into each phase, clear of the edge where the output mux moves
    always @(posedge k_clk or negedge k_clk) begin
        #20;
        sq[hc % 1024] = dq_out;
        so[hc % 1024] = dq_oe;
    end

    // controls for the next rise, words half a cycle early
    task automatic step(input logic ld_n, input logic rw,
            input logic [AW-1:0] a, input ddrs_wr_t w, output int t);
        @(posedge k_clk);
        t = hc + 3;
        load_n <= ld_n;
        rd_wr <= ld_n ? ~rd_wr : rw;
        addr <= ld_n ? ~addr : a;
        dq_in <= pp_wr.vld ? pp_wr.w1 : ~dq_in;
        byte_lane_mask_n <= pp_wr.vld ? pp_wr.m1_n : ~byte_lane_mask_n;
        @(negedge k_clk);
        dq_in <= p_wr.vld ? p_wr.w0 : ~dq_in;
        byte_lane_mask_n <= p_wr.vld ? p_wr.m0_n : ~byte_lane_mask_n;
        pp_wr = p_wr;
        p_wr = w;
        p_wr.vld = w.vld & ~ld_n & ~rw;
    endtask
endmodule

// >>> tb/tb_ddr_burst2_sram_interface.sv
// Self-checking bench for the burst-of-two DDR SRAM core.
// Assumes the controller model owns every link-side input.
`timescale 1ns/1ns
module tb_ddr_burst2_sram_interface;
    import ddrs_pkg::*;
    logic mclk, rst, dll_disable_n, c_clk_p, c_clk_n, busy_seen;
    wire k_clk, load_n, rd_wr, dq_oe, single_clock_mode;
    wire dll_locked, imp_update, link_busy;
    wire [AW-1:0] addr;
    wire [LANES-1:0] msk;
    wire [DW-1:0] dq_in, dq_out;
    int num_errors = 0;
    int check_count = 0;
    int ncyc = 0;
    int t, n;

    ddrs_core dut (.mclk(mclk), .rst(rst), .k_clk(k_clk), .load_n(load_n),
        .rd_wr(rd_wr), .addr(addr), .byte_lane_mask_n(msk), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dll_disable_n(dll_disable_n),
        .c_clk_p(c_clk_p), .c_clk_n(c_clk_n),
        .single_clock_mode(single_clock_mode), .dll_locked(dll_locked),
        .imp_update(imp_update), .link_busy(link_busy));
    ddrs_ctrl_model ctl (.k_clk(k_clk), .load_n(load_n), .rd_wr(rd_wr),
        .addr(addr), .byte_lane_mask_n(msk), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));

    // System clock, 40 ns
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Cycle count, busy watch and hang guard
    always @(negedge mclk) begin
        ncyc <= ncyc + 1;
        if (link_busy === 1'b1) begin
            busy_seen <= 1'b1;
        end
        if (ncyc == 8000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [DW-1:0] seen,
            input logic [DW-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Two system cycles; the link side is set at once, released on k_clk
    task automatic do_reset(input logic strap, input logic dll);
        @(posedge mclk);
        rst <= 1'b1;
        c_clk_p <= strap;
        c_clk_n <= strap;
        dll_disable_n <= dll;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0,
            input logic [DW-1:0] w1, input logic [LANES-1:0] m0,
            input logic [LANES-1:0] m1);
        ctl.step(1'b0, 1'b0, a, '{1'b1, a, w0, w1, m0, m1}, t);
    endtask

    task automatic rd(input logic [AW-1:0] a, output int tr);
        ctl.step(1'b0, 1'b1, a, '0, tr);
    endtask

    task automatic nop(input int k);
        repeat (k) ctl.step(1'b1, 1'b0, ADDR_RST, '0, t);
    endtask

    // Both words and the enable around them; late shifts half a cycle
    task automatic chk_rd(input int tr, input int late,
            input logic [DW-1:0] e0, input logic [DW-1:0] e1,
            input logic last);
        int i;
        i = tr + 2 + late;
        check("word0", ctl.sq[i % 1024], e0);
        check("word1", ctl.sq[(i + 1) % 1024], e1);
        check("oe", 18'({ctl.so[i % 1024], ctl.so[(i + 1) % 1024],
            ctl.so[(i + 2) % 1024]}), 18'({2'h3, ~last}));
    endtask

    task automatic wait_imp();
        n = 0;
        while (imp_update !== 1'b1 && n < 1100) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic t_reset();
        check("oe", 18'(dq_oe), 18'h0);
        check("scm", 18'(single_clock_mode), 18'h0);
        nop(6);
        check("idle oe", 18'(dq_oe), 18'h0);
        $display("test reset done");
    endtask

    task automatic t_basic();
        int t1, t2;
        wr(22'h000010, 18'h00111, 18'h00222, MASK_ALL, MASK_ALL);
        wr(22'h000013, 18'h00333, 18'h00444, MASK_ALL, MASK_ALL);
        nop(2);
        rd(22'h000011, t1);
        rd(22'h000012, t2);
        nop(4);
        chk_rd(t1, 0, 18'h00222, 18'h00111, 1'b0);
        chk_rd(t2, 0, 18'h00444, 18'h00333, 1'b1);
        $display("test basic done");
    endtask

    task automatic t_mask();
        int t1;
        wr(22'h000020, 18'h3FFFF, 18'h3FFFF, MASK_ALL, MASK_ALL);
        wr(22'h000020, 18'h00000, 18'h00000, 2'h1, 2'h2);
        nop(3);
        rd(22'h000020, t1);
        nop(4);
        chk_rd(t1, 0, 18'h001FF, 18'h3FE00, 1'b1);
        $display("test mask done");
    endtask

    task automatic t_status();
        int t1;
        n = 0;
        while (dll_locked !== 1'b1 && n < 1100) begin
            @(negedge mclk);
            n++;
        end
        check("lock time", 18'(n >= 1016 && n <= 1040), 18'h1);
        wait_imp();
        t1 = ncyc;
        @(negedge mclk);
        check("imp width", 18'(imp_update), 18'h0);
        wait_imp();
        check("imp gap", 18'(ncyc - t1), 18'h400);
        @(posedge mclk);
        dll_disable_n <= 1'b0;
        repeat (10) @(negedge mclk);
        check("unlock", 18'(dll_locked), 18'h0);
        @(posedge mclk);
        dll_disable_n <= 1'b1;
        check("scm", 18'(single_clock_mode), 18'h1);
        $display("test status done");
    endtask

    task automatic t_bypass();
        int t1, t2, t3, t4;
        nop(4);
        busy_seen = 1'b0;
        wr(22'h000030, 18'h0AAAA, 18'h05555, MASK_ALL, MASK_ALL);
        rd(22'h000030, t1);
        rd(22'h000031, t2);
        nop(1);
        wr(22'h000040, 18'h01234, 18'h04321, MASK_ALL, MASK_ALL);
        nop(4);
        rd(22'h000030, t3);
        rd(22'h000041, t4);
        nop(5);
        chk_rd(t1, 1, 18'h0AAAA, 18'h05555, 1'b0);
        chk_rd(t2, 1, 18'h05555, 18'h0AAAA, 1'b1);
        chk_rd(t3, 1, 18'h0AAAA, 18'h05555, 1'b0);
        chk_rd(t4, 1, 18'h04321, 18'h01234, 1'b1);
        check("busy seen", 18'(busy_seen), 18'h1);
        n = 0;
        while (link_busy !== 1'b0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        check("busy end", 18'(link_busy), 18'h0);
        $display("test bypass done");
    endtask

    // Main sequence; second reset mid-run changes strap and DLL pin
    initial begin
        rst = 1'b1;
        dll_disable_n = 1'b0;
        c_clk_p = 1'b0;
        c_clk_n = 1'b0;
        busy_seen = 1'b0;
        do_reset(1'b0, 1'b0);
        t_reset();
        t_basic();
        t_mask();
        do_reset(1'b1, 1'b1);
        t_status();
        t_bypass();
        test_done();
    end
endmodule
